// ==== filter_coprocessor.sv ====
// Filter coprocessor: sample FIFOs, history and coefficient init, FIR/IIR multiply-accumulate engine.
//
// Functional notes
// - History must hold coefficient-count prior samples before first result.
// - Preload bit set: host fills history first, first input filtered at once.
// - Preload clear: first coefficient-count inputs load history, then compute starts.
// - Coef-init set: constant write fills coefficients with constant times history.
// - Both inits: load history, await constant, fill coefficients, need one input.
// - Decimation ratio is field plus one, 1 to 16; not with multichannel.
// - Real and magnitude: one output per ratio-count inputs.
// - Complex modes take twice ratio inputs; complex gives two outputs, alternating one.
// - Filter-type bit set selects IIR: input plus weighted past outputs.
// - IIR: accumulate, add input, push output, advance base pointer, store output.
// - IIR ignores operation mode; real or multichannel, one output per input.
// - IIR never self-initializes and ignores preload; no decimation.
// - Rounding field: 00 convergent, 01 two's complement, 10 truncation.
// - Scale 1, 8 or 16 applies only to IIR and coefficient updates.
// - IIR scale-select set scales feedback only; clear scales whole sum.
// - Update scale-select set scales product term only; clear scales sum.
// - Input FIFO is eight 32-bit entries written at one address.
// - Output FIFO is eight 32-bit entries read from one address.
// - Input-not-full while a slot is free; input-empty while all free.
// - Input-empty is set right when the block gets enabled.
// - Output-not-empty while one result held; output-full while eight held.
// - Filter-type clear selects FIR: sum of coefficients times inputs.
// - Multichannel: channel count is field plus one, samples interleaved per period.
`timescale 1ns/1ps
module filter_coprocessor #(
  parameter int MEM_DEPTH  = filter_coprocessor_pkg::MEM_DEPTH,
  parameter int FIFO_DEPTH = filter_coprocessor_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic                                  clk,
  input  wire logic                                  reset_n,
  // Register port.
  input  wire filter_coprocessor_pkg::bus_req_s      bus_req,
  output logic [filter_coprocessor_pkg::DATA_W-1:0]  rdata,
  // Transfer flags for polling or a DMA engine.
  output filter_coprocessor_pkg::flags_s             flags
);
  import filter_coprocessor_pkg::*;

  localparam int PW = $clog2(MEM_DEPTH);
  localparam int FW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_WAIT_K, ST_COEF, ST_WAIT_IN, ST_MAC, ST_PUSH} state_e;

  state_e                   state;
  ctrl_s                    ctrl;
  alu_s                     alu;
  chdec_s                   chdec;
  logic [PW-1:0]            tap_count;
  logic [PW-1:0]            base;
  logic [PW-1:0]            tap_idx;
  logic [PW-1:0]            load_cnt;
  logic [5:0]               in_cnt;
  logic [DATA_W-1:0]        k_reg;
  logic                     k_pending;
  logic [DATA_W-1:0]        w_reg;
  logic                     pass_im;
  logic                     alt_im;
  logic signed [ACC_W-1:0]  acc;
  logic [DATA_W-1:0]        hist_mem [MEM_DEPTH];
  logic [DATA_W-1:0]        coef_mem [MEM_DEPTH];
  logic [DATA_W-1:0]        in_mem   [FIFO_DEPTH];
  logic [DATA_W-1:0]        out_mem  [FIFO_DEPTH];
  logic [FW-1:0]            in_wp, in_rp, out_wp, out_rp;
  logic [CW-1:0]            in_count, out_count;

  function automatic logic signed [ACC_W-1:0] scaled(input logic signed [ACC_W-1:0] v, input logic [1:0] sc);
    case (sc)
      SCL_X8:  scaled = v <<< SHIFT_X8;
      SCL_X16: scaled = v <<< SHIFT_X16;
      default: scaled = v;
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] round_q(input logic signed [ACC_W-1:0] v, input logic [1:0] md);
    logic half;
    logic rest;
    logic up;
    half = v[FRAC_LSB-1];
    rest = |v[FRAC_LSB-2:0];
    up   = 1'b0;
    if (md == RND_CONV) begin
      up = half && (rest || v[FRAC_LSB]);
    end else if (md == RND_TWOS) begin
      up = half;
    end
    round_q = v[FRAC_LSB+DATA_W-1:FRAC_LSB] + {{(DATA_W-1){1'b0}}, up};
  endfunction

  // Address decode.
  wire [1:0]    win      = bus_req.addr[ADDR_W-1:ADDR_W-2];
  wire [PW-1:0] win_idx  = bus_req.addr[PW+1:2];
  wire          wr_ctrl  = bus_req.wr && bus_req.addr == OFF_CTRL;
  wire          wr_k     = bus_req.wr && bus_req.addr == OFF_K;
  wire          wr_in    = bus_req.wr && bus_req.addr == OFF_IN;
  wire          rd_out   = bus_req.rd && bus_req.addr == OFF_OUT;
  wire          wr_hist  = bus_req.wr && win == WIN_HIST;
  wire          wr_coef  = bus_req.wr && win == WIN_COEF;
  wire          enable_rise = wr_ctrl && bus_req.wdata[0] && !ctrl.enable;
  wire ctrl_s   new_ctrl = ctrl_s'(bus_req.wdata[$bits(ctrl_s)-1:0]);

  // Mode decode.
  wire          iir      = ctrl.filter_type;
  wire          cplx     = !iir && (ctrl.op_mode == MODE_CPLX || ctrl.op_mode == MODE_ALT);
  wire          mag      = !iir && ctrl.op_mode == MODE_MAG;
  wire [4:0]    ratio    = (ctrl.multichannel || iir) ? 5'd1 : {1'b0, chdec.decim} + 5'd1;
  wire [5:0]    need     = cplx ? {ratio, 1'b0} : {1'b0, ratio};
  wire [6:0]    nch      = ctrl.multichannel ? {1'b0, chdec.channel_count} + 7'd1 : 7'd1;

  // Tap addressing: a channel's samples sit one channel-count apart in the history ring.
  wire [PW-1:0] off_word = (cplx && !pass_im) ? (tap_idx ^ {{(PW-1){1'b0}}, 1'b1}) : tap_idx;
  wire [PW+6:0] off_full = off_word * nch;
  // IIR taps start one period back, at this channel's own previous output.
  wire [PW-1:0] iir_lag  = (iir && ctrl.multichannel) ? PW'(chdec.channel_count) : '0;
  wire [PW-1:0] hist_addr = base - off_full[PW-1:0] - iir_lag;
  wire [DATA_W-1:0] hist_val = hist_mem[hist_addr];
  wire [DATA_W-1:0] mul_a  = (state == ST_COEF) ? k_reg : (mag ? hist_val : coef_mem[tap_idx]);
  wire signed [2*DATA_W-1:0] prod = $signed(mul_a) * $signed(hist_val);
  wire signed [ACC_W-1:0] prod_ext = ACC_W'(prod);
  wire          neg      = cplx && !pass_im && tap_idx[0];
  wire signed [ACC_W-1:0] acc_next = neg ? acc - prod_ext : acc + prod_ext;

  // Result shaping.
  wire signed [ACC_W-1:0] w_ext = ACC_W'($signed(w_reg)) <<< FRAC_LSB;
  wire signed [ACC_W-1:0] iir_total = alu.scale_select ? w_ext + scaled(acc, alu.scale)
                                                      : scaled(w_ext + acc, alu.scale);
  wire signed [ACC_W-1:0] old_coef = '0;
  wire signed [ACC_W-1:0] coef_total = alu.scale_select ? old_coef + scaled(prod_ext, alu.scale)
                                                       : scaled(old_coef + prod_ext, alu.scale);
  wire [DATA_W-1:0] result   = round_q(iir ? iir_total : acc, alu.rounding);
  wire [DATA_W-1:0] new_coef = round_q(coef_total, alu.rounding);

  // FIFO control.
  wire          in_full  = in_count == CW'(FIFO_DEPTH);
  wire          out_full = out_count == CW'(FIFO_DEPTH);
  wire          in_push  = wr_in && !in_full;
  wire          in_pop   = (state == ST_LOAD || state == ST_WAIT_IN) && ctrl.enable && in_count != '0;
  wire          out_push = state == ST_PUSH && !out_full;
  wire          out_pop  = rd_out && out_count != '0;
  wire [DATA_W-1:0] in_data = in_mem[in_rp];
  wire          last_in  = in_cnt == need - 6'd1;

  assign flags.input_not_full   = !in_full;
  assign flags.input_empty      = in_count == '0;
  assign flags.output_not_empty = out_count != '0;
  assign flags.output_full      = out_full;

  // History write port: engine stores inputs (FIR) or outputs (IIR) at the advanced base.
  wire          eng_hist_we = in_pop && (state == ST_LOAD || !iir) || (out_push && iir);
  wire [PW-1:0] eng_hist_wa = base + PW'(1);
  wire [DATA_W-1:0] eng_hist_wd = (state == ST_PUSH) ? result : in_data;

  // Read selection.
  logic [DATA_W-1:0] rd_sel;
  always_comb begin
    rd_sel = '0;
    if (win == WIN_HIST) begin
      rd_sel = hist_mem[win_idx];
    end else if (win == WIN_COEF) begin
      rd_sel = coef_mem[win_idx];
    end else begin
      case (bus_req.addr)
        OFF_CTRL:  rd_sel = DATA_W'(ctrl);
        OFF_TAPS:  rd_sel = DATA_W'(tap_count);
        OFF_CHDEC: rd_sel = DATA_W'(chdec);
        OFF_ALU:   rd_sel = DATA_W'(alu);
        OFF_K:     rd_sel = k_reg;
        OFF_FLAGS: rd_sel = DATA_W'(flags);
        OFF_OUT:   rd_sel = out_count != '0 ? out_mem[out_rp] : '0;
        OFF_BASE:  rd_sel = DATA_W'(base);
        default:   rd_sel = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else begin
      rdata <= bus_req.rd ? rd_sel : '0;
    end
  end

  // Memories carry no reset.
  always_ff @(posedge clk) begin
    if (eng_hist_we) begin
      hist_mem[eng_hist_wa] <= eng_hist_wd;
    end else if (wr_hist) begin
      hist_mem[win_idx] <= bus_req.wdata;
    end
    if (state == ST_COEF) begin
      coef_mem[tap_idx] <= new_coef;
    end else if (wr_coef) begin
      coef_mem[win_idx] <= bus_req.wdata;
    end
    if (in_push) begin
      in_mem[in_wp] <= bus_req.wdata;
    end
    if (out_push) begin
      out_mem[out_wp] <= result;
    end
  end

  // FIFO pointers; enabling the block flushes the input FIFO.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_wp     <= '0;
      in_rp     <= '0;
      in_count  <= '0;
      out_wp    <= '0;
      out_rp    <= '0;
      out_count <= '0;
    end else begin
      if (enable_rise) begin
        in_wp    <= '0;
        in_rp    <= '0;
        in_count <= '0;
      end else begin
        in_wp    <= in_wp + FW'(in_push);
        in_rp    <= in_rp + FW'(in_pop);
        in_count <= in_count + CW'(in_push) - CW'(in_pop);
      end
      out_wp    <= out_wp + FW'(out_push);
      out_rp    <= out_rp + FW'(out_pop);
      out_count <= out_count + CW'(out_push) - CW'(out_pop);
    end
  end

  // Configuration registers.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl      <= CTRL_RST;
      alu       <= ALU_RST;
      chdec     <= CHDEC_RST;
      tap_count <= '0;
      k_reg     <= '0;
      k_pending <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= new_ctrl;
      end
      if (bus_req.wr && bus_req.addr == OFF_ALU) begin
        alu <= alu_s'(bus_req.wdata[$bits(alu_s)-1:0]);
      end
      if (bus_req.wr && bus_req.addr == OFF_CHDEC) begin
        chdec <= chdec_s'(bus_req.wdata[$bits(chdec_s)-1:0]);
      end
      if (bus_req.wr && bus_req.addr == OFF_TAPS) begin
        tap_count <= bus_req.wdata[PW-1:0];
      end
      if (wr_k) begin
        k_reg <= bus_req.wdata;
      end
      // A new constant write wins over its consumption in the same cycle.
      if (wr_k) begin
        k_pending <= 1'b1;
      end else if (state == ST_WAIT_K) begin
        k_pending <= 1'b0;
      end
    end
  end

  // Filter engine.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= ST_IDLE;
      base     <= '0;
      tap_idx  <= '0;
      load_cnt <= '0;
      in_cnt   <= '0;
      w_reg    <= '0;
      pass_im  <= 1'b0;
      alt_im   <= 1'b0;
      acc      <= '0;
    end else if (bus_req.wr && bus_req.addr == OFF_BASE) begin
      base <= bus_req.wdata[PW-1:0];
    end else if (!ctrl.enable) begin
      state <= ST_IDLE;
      if (enable_rise) begin
        load_cnt <= '0;
        in_cnt   <= '0;
        alt_im   <= 1'b0;
        if (new_ctrl.filter_type || new_ctrl.history_preload) begin
          state <= (new_ctrl.coef_init && !new_ctrl.filter_type) ? ST_WAIT_K : ST_WAIT_IN;
        end else begin
          state <= ST_LOAD;
        end
      end
    end else begin
      case (state)
        ST_LOAD: begin
          if (in_pop) begin
            base     <= eng_hist_wa;
            load_cnt <= load_cnt + PW'(1);
            tap_idx  <= '0;
            acc      <= '0;
            pass_im  <= alt_im;
            if (load_cnt == tap_count) begin
              state <= ctrl.coef_init ? ST_WAIT_K : ST_MAC;
            end
          end
        end
        ST_WAIT_K: begin
          tap_idx <= '0;
          if (k_pending) begin
            state <= ST_COEF;
          end
        end
        ST_COEF: begin
          tap_idx <= tap_idx + PW'(1);
          if (tap_idx == tap_count) begin
            state <= ST_WAIT_IN;
          end
        end
        ST_WAIT_IN: begin
          tap_idx <= '0;
          acc     <= '0;
          pass_im <= ctrl.op_mode == MODE_ALT && alt_im;
          if (in_pop) begin
            if (iir) begin
              w_reg <= in_data;
              state <= ST_MAC;
            end else begin
              base   <= eng_hist_wa;
              in_cnt <= last_in ? 6'd0 : in_cnt + 6'd1;
              if (last_in) begin
                state <= ST_MAC;
              end
            end
          end
        end
        ST_MAC: begin
          acc     <= acc_next;
          tap_idx <= tap_idx + PW'(1);
          if (tap_idx == tap_count) begin
            state <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (out_push) begin
            if (iir) begin
              base <= eng_hist_wa;
            end
            if (cplx && ctrl.op_mode == MODE_CPLX && !pass_im) begin
              pass_im <= 1'b1;
              acc     <= '0;
              tap_idx <= '0;
              state   <= ST_MAC;
            end else begin
              alt_im <= (cplx && ctrl.op_mode == MODE_ALT) ? !alt_im : 1'b0;
              state  <= ST_WAIT_IN;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_second_pass;
    state == ST_MAC ##1 state == ST_MAC;
  endsequence
  property p_in_full_hold;
    wr_in && in_full && !in_pop && !enable_rise |=> in_count == CW'(FIFO_DEPTH);
  endproperty
  a_in_full_hold: assert property (p_in_full_hold) else $error("full input fifo changed on write");
  property p_out_empty_hold;
    bus_req.rd && bus_req.addr == OFF_OUT && out_count == '0 && !out_push |=> out_count == '0;
  endproperty
  a_out_empty_hold: assert property (p_out_empty_hold) else $error("empty output fifo changed on read");
  property p_enable_empty;
    enable_rise |=> flags.input_empty && flags.input_not_full;
  endproperty
  a_enable_empty: assert property (p_enable_empty) else $error("input not empty after enable");
  property p_out_flags;
    out_count == CW'(FIFO_DEPTH) |-> flags.output_full && flags.output_not_empty;
  endproperty
  a_out_flags: assert property (p_out_flags) else $error("output flags wrong when full");
  property p_load_then_mac;
    state == ST_LOAD && in_pop && load_cnt == tap_count && !ctrl.coef_init && !bus_req.wr |=> state == ST_MAC;
  endproperty
  a_load_then_mac: assert property (p_load_then_mac) else $error("compute did not follow history load");
  property p_iir_base;
    state == ST_PUSH && out_push && iir && !bus_req.wr |=> base == $past(base) + PW'(1);
  endproperty
  a_iir_base: assert property (p_iir_base) else $error("base not advanced after iir output");
  property p_k_wait;
    state == ST_WAIT_K && !k_pending && ctrl.enable && !bus_req.wr |=> state == ST_WAIT_K;
  endproperty
  a_k_wait: assert property (p_k_wait) else $error("coefficient fill started without constant");
  property p_decim_hold;
    state == ST_WAIT_IN && in_pop && !iir && !last_in && !bus_req.wr |=> state == ST_WAIT_IN;
  endproperty
  a_decim_hold: assert property (p_decim_hold) else $error("output computed before ratio inputs");
  property p_iir_no_load;
    enable_rise && new_ctrl.filter_type |=> state != ST_LOAD;
  endproperty
  a_iir_no_load: assert property (p_iir_no_load) else $error("iir entered history load");
  property p_cplx_two;
    state == ST_PUSH && out_push && ctrl.op_mode == MODE_CPLX && !iir && !pass_im && !bus_req.wr
      && tap_count != '0 |=> s_second_pass;
  endproperty
  a_cplx_two: assert property (p_cplx_two) else $error("complex mode missed second output");
endmodule

// ==== filter_coprocessor_pkg.sv ====
// Package with register map, field layouts and shared types of the filter coprocessor.
package filter_coprocessor_pkg;
  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 10;
  localparam int ACC_W      = 72;
  localparam int FIFO_DEPTH = 8;
  localparam int MEM_DEPTH  = 64;
  localparam int FRAC_LSB   = 31;

  localparam logic [ADDR_W-1:0] OFF_CTRL  = 10'h000;
  localparam logic [ADDR_W-1:0] OFF_TAPS  = 10'h004;
  localparam logic [ADDR_W-1:0] OFF_CHDEC = 10'h008;
  localparam logic [ADDR_W-1:0] OFF_ALU   = 10'h00C;
  localparam logic [ADDR_W-1:0] OFF_K     = 10'h010;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 10'h014;
  localparam logic [ADDR_W-1:0] OFF_IN    = 10'h018;
  localparam logic [ADDR_W-1:0] OFF_OUT   = 10'h01C;
  localparam logic [ADDR_W-1:0] OFF_BASE  = 10'h020;
  localparam logic [1:0]        WIN_HIST  = 2'h1;
  localparam logic [1:0]        WIN_COEF  = 2'h2;

  localparam logic [1:0] MODE_REAL = 2'h0;
  localparam logic [1:0] MODE_CPLX = 2'h1;
  localparam logic [1:0] MODE_ALT  = 2'h2;
  localparam logic [1:0] MODE_MAG  = 2'h3;
  localparam logic [1:0] RND_CONV  = 2'h0;
  localparam logic [1:0] RND_TWOS  = 2'h1;
  localparam logic [1:0] SCL_X8    = 2'h1;
  localparam logic [1:0] SCL_X16   = 2'h2;
  localparam int         SHIFT_X8  = 3;
  localparam int         SHIFT_X16 = 4;

  typedef struct packed {
    logic       multichannel;
    logic [1:0] op_mode;
    logic       coef_init;
    logic       history_preload;
    logic       filter_type;
    logic       enable;
  } ctrl_s;

  typedef struct packed {
    logic [1:0] scale;
    logic       scale_select;
    logic [1:0] rounding;
  } alu_s;

  typedef struct packed {
    logic [5:0] channel_count;
    logic [3:0] decim;
  } chdec_s;

  typedef struct packed {
    logic output_full;
    logic output_not_empty;
    logic input_empty;
    logic input_not_full;
  } flags_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_s;

  localparam ctrl_s  CTRL_RST  = '0;
  localparam alu_s   ALU_RST   = '0;
  localparam chdec_s CHDEC_RST = '0;
endpackage

// ==== host_model.sv ====
// Polling host model that drives the block's register port.
`timescale 1ns/1ps
module host_model (
  // Clock.
  input  wire logic                                      clk,
  // Register port and flags.
  output filter_coprocessor_pkg::bus_req_s               bus_req,
  input  wire logic [filter_coprocessor_pkg::DATA_W-1:0] rdata,
  input  wire filter_coprocessor_pkg::flags_s            flags
);
  import filter_coprocessor_pkg::*;
  initial bus_req = '0;
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus_req <= {a, d, 2'b10};
    @(posedge clk);
    bus_req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    bus_req <= {a, 32'h0, 2'b01};
    @(posedge clk);
    bus_req <= '0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  // One word moves once its flag shows room or a result, or after 400 cycles of waiting.
  task automatic push(input logic [DATA_W-1:0] d);
    for (int i = 0; i < 400 && !flags.input_not_full; i++) @(posedge clk);
    wr(OFF_IN, d);
  endtask
  task automatic pop(output logic [DATA_W-1:0] d);
    for (int i = 0; i < 400 && !flags.output_not_empty; i++) @(posedge clk);
    rd(OFF_OUT, d);
  endtask
endmodule

// ==== filter_coprocessor_bench.sv ====
// Self-checking bench for FIR, IIR and FIFO behaviour through a polling host.
`timescale 1ns/1ps
module filter_coprocessor_bench;
  import filter_coprocessor_pkg::*;
  localparam logic [DATA_W-1:0] HALF = 32'h4000_0000;
  localparam logic [DATA_W-1:0] QTR  = 32'h2000_0000;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  bus_req_s          bus_req;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] v;
  flags_s            flags;
  int                fail_count = 0;
  int                checked = 0;

  always #2.5 clk = ~clk;

  filter_coprocessor u_dut (.clk(clk), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata), .flags(flags));
  host_model host (.clk(clk), .bus_req(bus_req), .rdata(rdata), .flags(flags));

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // Flags are sampled mid-cycle, after w idle cycles.
  task automatic chkf(input string n, input logic [3:0] e, input int w);
    repeat (w) @(posedge clk);
    @(negedge clk);
    chk(n, 32'(e), 32'(flags));
    @(posedge clk);
  endtask

  task automatic rdchk(input string n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    host.rd(a, v);
    chk(n, e, v);
  endtask

  task automatic popchk(input string n, input logic [DATA_W-1:0] e);
    host.pop(v);
    chk(n, e, v);
  endtask

  // Reprograms the disabled block, then enables it with the given control word.
  task automatic setup(input logic [5:0] t, input logic [4:0] alu, input logic [9:0] d,
                       input logic [DATA_W-1:0] c0, input logic [DATA_W-1:0] h0, input logic [6:0] ctl);
    host.wr(OFF_CTRL, 32'h0);
    host.wr(OFF_TAPS, 32'(t));
    host.wr(OFF_ALU, 32'(alu));
    host.wr(OFF_CHDEC, 32'(d));
    host.wr(OFF_BASE, 32'h0);
    host.wr(10'h200, c0);
    host.wr(10'h100, h0);
    host.wr(OFF_CTRL, 32'(ctl));
  endtask

  task automatic t_fifo();
    for (int i = 0; i < 9; i++) host.wr(OFF_IN, 32'(i));
    chkf("in full", 4'h0, 0);
    host.wr(OFF_CTRL, 32'h1);
    chkf("on enable", 4'h3, 0);
  endtask

  task automatic t_fir(input logic [6:0] ctl, input logic [DATA_W-1:0] e);
    host.wr(10'h204, HALF);
    setup(6'h01, 5'h00, 10'h000, HALF, HALF, ctl);
    host.push(QTR);
    if (!ctl[2]) begin
      chkf("one loaded", 4'h3, 20);
      host.push(QTR);
    end
    popchk("fir out", e);
  endtask

  // Scaling is set here but must leave the FIR result alone.
  task automatic t_decim(input logic [3:0] d);
    setup(6'h00, 5'h08, 10'(d), HALF, HALF, 7'h05);
    for (int i = 0; i < d; i++) host.push(QTR);
    chkf("decim wait", 4'h3, 20);
    host.push(HALF);
    popchk("decim out", QTR);
  endtask

  // The constant is chosen so that every scale gives a coefficient of one quarter.
  task automatic t_coef_init(input logic [4:0] alu, input logic [DATA_W-1:0] k);
    setup(6'h00, alu, 10'h000, HALF, HALF, 7'h0D);
    host.wr(OFF_K, k);
    chkf("after k", 4'h3, 20);
    host.push(HALF);
    popchk("init out", 32'h1000_0000);
  endtask

  // Coefficient 0.5+0.25j against input 0.5+0.25j gives 0.1875+0.25j.
  task automatic t_cplx(input logic [6:0] ctl);
    host.wr(10'h204, QTR);
    setup(6'h01, 5'h00, 10'h000, HALF, HALF, ctl);
    host.push(HALF);
    chkf("cplx half pair", 4'h3, 20);
    host.push(QTR);
    popchk("cplx re", 32'h1800_0000);
    if (ctl[5]) begin
      chkf("alt single", 4'h3, 20);
      host.push(HALF);
      host.push(QTR);
    end
    popchk("cplx im", 32'h2000_0000);
  endtask

  task automatic t_mag();
    setup(6'h00, 5'h00, 10'h001, 32'h0, HALF, 7'h35);
    host.push(QTR);
    chkf("mag wait", 4'h3, 20);
    host.push(HALF);
    popchk("mag out", QTR);
  endtask

  // Two interleaved channels; the decimation field is set and must be ignored.
  task automatic t_multi();
    host.wr(10'h204, HALF);
    host.wr(10'h1FC, 32'h0);
    setup(6'h01, 5'h00, 10'h012, HALF, HALF, 7'h45);
    host.push(HALF);
    host.push(QTR);
    host.push(32'h0);
    popchk("chan0 out", QTR);
    popchk("chan1 out", 32'h3000_0000);
    popchk("chan0 next", QTR);
  endtask

  task automatic t_iir(input logic [DATA_W-1:0] h, input logic [4:0] alu, input logic [DATA_W-1:0] e);
    setup(6'h00, alu, 10'h000, HALF, h, 7'h03);
    host.push(32'h0100_0000);
    popchk("iir out", e);
    rdchk("iir base", OFF_BASE, 32'h1);
    rdchk("iir kept", 10'h104, e);
  endtask

  task automatic t_full();
    setup(6'h00, 5'h00, 10'h000, 32'h0, 32'h0, 7'h03);
    for (int i = 1; i < 10; i++) host.push(32'(i));
    repeat (40) @(posedge clk);
    @(negedge clk);
    chk("out full", 32'h3, 32'(flags[3:2]));
    @(posedge clk);
    for (int i = 1; i < 10; i++) popchk("drain", 32'(i));
    rdchk("empty read", OFF_OUT, 32'h0);
    chkf("drained", 4'h3, 0);
  endtask

  initial begin
    chkf("in reset", 4'h3, 4);
    reset_n <= 1'b1;
    @(posedge clk);
    t_fifo();
    t_fir(7'h01, QTR);
    t_fir(7'h05, 32'h3000_0000);
    t_decim(4'h2);
    t_decim(4'hF);
    t_coef_init(5'h00, HALF);
    t_coef_init(5'h08, 32'h0800_0000);
    t_coef_init(5'h14, 32'h0400_0000);
    t_cplx(7'h15);
    t_cplx(7'h25);
    t_mag();
    t_multi();
    t_iir(32'h0200_0000, 5'h04, 32'h0200_0000);
    t_iir(32'h0200_0000, 5'h0C, 32'h0900_0000);
    t_iir(32'h0200_0000, 5'h14, 32'h1100_0000);
    t_iir(32'h0200_0000, 5'h08, 32'h1000_0000);
    t_iir(32'h0000_0001, 5'h00, 32'h0100_0000);
    t_iir(32'h0000_0001, 5'h01, 32'h0100_0001);
    t_iir(32'h0000_0003, 5'h02, 32'h0100_0001);
    t_iir(32'h0000_0003, 5'h00, 32'h0100_0002);
    t_full();
    close_out();
  end

  initial begin
    #200_000;
    fail_count++;
    close_out();
  end
endmodule
